// [rtl/power_up_sequencer.sv]
// power-up sequencer: latch mode pins, pre-sequence, slotted enables
// assumes mode pins tied on the board and async pins synchronised here
`timescale 1ns/100ps
`default_nettype none
module power_up_sequencer #(
  parameter logic [8:0] INIT_T = 9'(pwrseq_pkg::INIT_TICKS),
  parameter logic [8:0] SLOT_T = 9'(pwrseq_pkg::SLOT_TICKS),
  parameter logic [8:0] PWM_T  = 9'(pwrseq_pkg::PWM_TICKS)
) (
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  input  wire logic [4:0]           power_mode_select_pins_i,
  input  wire logic                 power_cut_event_i,
  input  wire logic                 battery_uv_i,
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [31:0]          reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic [31:0]               reg_rdata_o,
  output logic                      digital_core_supply_en_o,
  output logic                      secure_clock_regulator_en_o,
  output logic                      analog_core_supply_en_o,
  output logic [12:0]               reg_en_o,
  output logic [4:0]                buck_discharge_o,
  output logic [9:0]                buck_mode_o,
  output pwrseq_pkg::level_s        levels_o,
  output logic                      pass_device_internal_o,
  output logic                      battery_uv_o,
  output logic                      uv_mask_o
);
  import pwrseq_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // functions

  // enables that come on at the start of a slot
  function automatic logic [12:0] slot_set(logic tab_b, logic [3:0] s);
    logic [12:0] r;
    r = '0;
    if (!tab_b) begin
      case (s)
        4'h0: r[R_B2] = 1'b1;
        4'h1: r[R_PLL] = 1'b1;
        4'h2: r[R_G2] = 1'b1;
        4'h3: r[R_B3] = 1'b1;
        4'h4: r[R_B1] = 1'b1;
        4'h5: begin r[R_B4] = 1'b1; r[R_MREF] = 1'b1; end
        4'h7: begin r[R_B5] = 1'b1; r[R_G1] = 1'b1; end
        4'h8: begin r[R_USB] = 1'b1; r[R_USB2] = 1'b1; end
        4'h9: r[R_DAC] = 1'b1;
        default: r = '0;
      endcase
    end else begin
      case (s)
        4'h0: r[R_B2] = 1'b1;
        4'h1: r[R_B3] = 1'b1;
        4'h2: r[R_B1] = 1'b1;
        4'h3: r[R_DAC] = 1'b1;
        4'h4: begin r[R_B4] = 1'b1; r[R_MREF] = 1'b1; end
        4'h5: r[R_B5] = 1'b1;
        4'h6: begin r[R_G2] = 1'b1; r[R_USB2] = 1'b1; end
        4'h7: r[R_PLL] = 1'b1;
        4'h8: r[R_G1] = 1'b1;
        4'h9: r[R_USB] = 1'b1;
        default: r = '0;
      endcase
    end
    return r;
  endfunction : slot_set

  // default levels for a valid configuration code
  function automatic level_s levels_of(logic [3:0] c);
    level_s l;
    logic   a_mid;
    a_mid = (c >= 4'h6) && (c <= CODE_A_HI);
    l.buck_pair_one = MV_1100;
    l.buck_five     = MV_1800;
    l.pll           = MV_1800;
    l.usb           = MV_3300;
    l.usb_two       = MV_2500;
    l.buck_two      = (c == 4'h5) ? MV_1225 : (a_mid ? MV_1300 : MV_1200);
    l.buck_three    = (c == 4'h6) ? MV_1300 : MV_1200;
    l.secure_clock  = a_mid ? MV_1300 : MV_1200;
    l.general_one   = a_mid ? MV_1300 : MV_1200;
    l.dac           = (c <= CODE_A_HI) ? MV_2775 : MV_2500;
    l.general_two   = (c >= 4'hA && c <= 4'hD) ? MV_3100 : MV_2500;
    case (c)
      4'h5, 4'h7: l.buck_pair_four_a = MV_1500;
      4'h6, 4'hA: l.buck_pair_four_a = MV_1800;
      4'h8:       l.buck_pair_four_a = MV_1350;
      4'h9, 4'hB: l.buck_pair_four_a = MV_1200;
      default:    l.buck_pair_four_a = MV_3150;
    endcase
    case (c)
      4'h5, 4'h7:        l.buck_pair_four_b = MV_1500;
      4'h6, 4'hA, 4'hD,
      4'hF:              l.buck_pair_four_b = MV_1800;
      4'h8:              l.buck_pair_four_b = MV_1350;
      default:           l.buck_pair_four_b = MV_1200;
    endcase
    return l;
  endfunction : levels_of

  //////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [4:0] pins_s1_q, pins_s2_q;
  logic       cut_s1_q, cut_s2_q, uv_s1_q, uv_s2_q;

  // pins come from the board, so two flops before any use
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pins_s1_q <= 5'h00;
      pins_s2_q <= 5'h00;
      cut_s1_q  <= 1'b0;
      cut_s2_q  <= 1'b0;
      uv_s1_q   <= 1'b0;
      uv_s2_q   <= 1'b0;
    end else begin
      pins_s1_q <= power_mode_select_pins_i;
      pins_s2_q <= pins_s1_q;
      cut_s1_q  <= power_cut_event_i;
      cut_s2_q  <= cut_s1_q;
      uv_s1_q   <= battery_uv_i;
      uv_s2_q   <= uv_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // control timebase

  logic [10:0] div_q;
  logic        tick;
  assign tick = (div_q == 11'(DIV_CYCLES - 1)); // R14

  // one-cycle enable at the control clock rate
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) div_q <= 11'h000;
    else if (tick) div_q <= 11'h000;
    else div_q <= div_q + 11'h001;
  end

  //////////////////////////////////////////////////////////////////////
  // sequencer

  state_e      state_q;
  logic [8:0]  cnt_q;
  logic [3:0]  slot_q;
  logic [1:0]  wait_q;
  logic [4:0]  code_q;
  logic        latched_q;
  logic [12:0] en_q;
  logic        rsvd, tab_b, slot_end;

  assign rsvd     = code_q[3:0] <= CODE_RSVD_HI; // R10 R15
  assign tab_b    = code_q[3:0] > CODE_A_HI;
  assign slot_end = tick && (cnt_q == SLOT_T - 9'h001);

  // latch once, after the sync chain holds real pin levels
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      code_q    <= 5'h00;
      latched_q <= 1'b0;
    end else if (state_q == ST_IDLE && wait_q == SYNC_WAIT
                 && !cut_s2_q) begin
      code_q    <= pins_s2_q; // R6 R7
      latched_q <= 1'b1; // R8
    end
  end

  // main flow; a power cut drops the regulators and analog supply but keeps the latch
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      cnt_q   <= 9'h000;
      slot_q  <= 4'h0;
      wait_q  <= 2'h0;
    end else if (cut_s2_q) begin
      state_q <= ST_CUT; // R8
      cnt_q   <= 9'h000;
      slot_q  <= 4'h0;
      wait_q  <= 2'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (wait_q == SYNC_WAIT) state_q <= ST_PRE;
          else wait_q <= wait_q + 2'h1;
        end
        ST_PRE: begin
          if (tick) begin
            if (cnt_q == INIT_T - 9'h001) begin // R1
              cnt_q   <= 9'h000;
              state_q <= rsvd ? ST_DONE : ST_SLOT; // R15
            end else cnt_q <= cnt_q + 9'h001;
          end
        end
        ST_SLOT: begin
          if (slot_end) begin // R2
            cnt_q <= 9'h000;
            if (slot_q == 4'(NUM_SLOTS - 1)) state_q <= ST_DONE;
            else slot_q <= slot_q + 4'h1;
          end else if (tick) cnt_q <= cnt_q + 9'h001;
        end
        ST_DONE: state_q <= ST_DONE;
        ST_CUT:  state_q <= latched_q ? ST_PRE : ST_IDLE; // R8
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // enables accumulate slot by slot; boost never comes on
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) en_q <= 13'h0000;
    else if (cut_s2_q || (state_q != ST_SLOT && state_q != ST_DONE))
      en_q <= 13'h0000; // R8
    else if (state_q == ST_SLOT) begin
      en_q <= en_q | slot_set(tab_b, slot_q); // R11 R12
    end
  end

  // core supplies: analog on from reset outside a cut, digital and secure clock from the latch onward
  assign analog_core_supply_en_o     = state_q != ST_CUT; // R9
  assign digital_core_supply_en_o    = latched_q; // R9
  assign secure_clock_regulator_en_o = latched_q; // R9
  assign reg_en_o         = en_q; // R10
  assign buck_discharge_o = ~en_q[4:0]; // R3
  assign uv_mask_o        = state_q != ST_DONE; // R4
  assign battery_uv_o     = uv_s2_q && !uv_mask_o; // R4
  assign pass_device_internal_o = code_q[4]; // R13

  // levels held in flops; reserved codes give zero
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) levels_o <= '0;
    else if (!latched_q || rsvd) levels_o <= '0; // R15
    else levels_o <= levels_of(code_q[3:0]); // R10
  end

  //////////////////////////////////////////////////////////////////////
  // PWM start and handover per buck

  logic [8:0] pwm_cnt_q [NUM_BUCKS];
  logic [4:0] force_pwm;
  logic [9:0] mode_q;

  // count control ticks since each buck was enabled
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NUM_BUCKS; i++) pwm_cnt_q[i] <= 9'h000;
    end else begin
      for (int i = 0; i < NUM_BUCKS; i++) begin
        if (!en_q[i]) pwm_cnt_q[i] <= 9'h000;
        else if (tick && force_pwm[i]) // R5
          pwm_cnt_q[i] <= pwm_cnt_q[i] + 9'h001;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_BUCKS; i++)
      force_pwm[i] = en_q[i] && (pwm_cnt_q[i] < PWM_T); // R5
  end

  // per-buck mode: PWM first, then the programmed one
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) buck_mode_o <= MODE_RST;
    else begin
      for (int i = 0; i < NUM_BUCKS; i++)
        buck_mode_o[2*i +: 2] <= force_pwm[i] ? MODE_PWM
                                              : mode_q[2*i +: 2]; // R5
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register port

  // programmed buck modes, written by software any time
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) mode_q <= MODE_RST;
    else if (reg_wr_i && reg_addr_i == ADDR_MODE) mode_q <= reg_wdata_i[9:0];
  end

  // read data stands while reg_rd_i is held, zero otherwise; unmapped reads zero
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) reg_rdata_o <= 32'h0000_0000;
    else if (!reg_rd_i) reg_rdata_o <= 32'h0000_0000;
    else begin
      case (reg_addr_i)
        ADDR_MODE:   reg_rdata_o <= {22'h000000, mode_q};
        ADDR_STATUS: reg_rdata_o <= {17'h00000, force_pwm, uv_mask_o,
                                     latched_q, code_q, state_q};
        ADDR_EN:     reg_rdata_o <= {19'h00000, en_q};
        default:     reg_rdata_o <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_pre_len_exact: assert property ( // R1
    state_q == ST_PRE && tick && cnt_q == INIT_T - 9'h001 && !cut_s2_q
    && !rsvd |=> state_q == ST_SLOT)
    else $error("pre phase length wrong");
  a_pre_no_regs: assert property ( // R1
    state_q == ST_PRE |-> en_q == 13'h0000)
    else $error("regulator on before slots");
  a_slot_step: assert property ( // R2
    state_q == ST_SLOT && $changed(slot_q) |-> $past(slot_end))
    else $error("slot advanced early");
  a_buck_discharge: assert property ( // R3
    $rose(reg_en_o[R_B2]) |-> !buck_discharge_o[R_B2]
    ##0 $past(buck_discharge_o[R_B2]))
    else $error("discharge not released on enable");
  a_uv_masked: assert property ( // R4
    state_q != ST_DONE |-> !battery_uv_o)
    else $error("uv seen while sequencing");
  a_pwm_start: assert property ( // R5
    $rose(reg_en_o[R_B2]) |=> buck_mode_o[2*R_B2 +: 2] == MODE_PWM
    [*2])
    else $error("buck not in PWM at start");
  a_pwm_handover: assert property ( // R5
    en_q[R_B2] && tick && pwm_cnt_q[R_B2] == PWM_T - 9'h001
    |=> ##1 buck_mode_o[2*R_B2 +: 2] == $past(mode_q[2*R_B2 +: 2]))
    else $error("mode not handed over");
  a_latch_held: assert property ( // R7
    latched_q && $past(latched_q) |-> $stable(code_q))
    else $error("latched code changed");
  a_cut_drops: assert property ( // R8
    cut_s2_q |=> reg_en_o == 13'h0000 && state_q == ST_CUT)
    else $error("power cut left supplies on");
  a_core_first: assert property ( // R9
    reg_en_o != 13'h0000 |-> digital_core_supply_en_o
    && secure_clock_regulator_en_o && analog_core_supply_en_o)
    else $error("core not up before regulators");
  a_boost_off: assert property ( // R10
    !reg_en_o[R_BST])
    else $error("boost enabled");
  a_order_first: assert property ( // R11 R12
    state_q == ST_SLOT && slot_q == 4'h0 && !cut_s2_q
    |=> reg_en_o == 13'h0002)
    else $error("slot zero not buck two only");
  a_pass_select: assert property ( // R13
    latched_q |-> pass_device_internal_o == code_q[4])
    else $error("pass device select wrong");
  a_rsvd_empty: assert property ( // R15
    latched_q && rsvd |-> reg_en_o == 13'h0000 && &buck_discharge_o)
    else $error("reserved code enabled regulators");

  c_seq_done:  cover property (state_q == ST_SLOT ##1 state_q == ST_DONE);
  c_cut_pre:   cover property (state_q == ST_PRE ##1 state_q == ST_CUT);
  c_rsvd_done: cover property (rsvd && latched_q && state_q == ST_DONE);
endmodule : power_up_sequencer
`default_nettype wire

// [shared/pwrseq_pkg.sv]
// constants, types and timing for the power-up sequencer
// assumes a 40 MHz system clock and a 32.768 kHz control timebase
// Behaviour
// R1 - wait 8.0 ms with only core up
// R2 - enable regulators in 2.0 ms slots
// R3 - unenabled buck outputs keep weak pull-downs
// R4 - ignore battery under-voltage while sequencing
// R5 - bucks start PWM, programmed mode after 3.0 ms
// R6 - five mode pins pick enables and levels
// R7 - latch mode pins before regulators enable
// R8 - power cut keeps latch, no stray supplies
// R9 - core digital, secure clock, analog up first
// R10 - code picks levels, reserved codes, boost off
// R11 - slot order for codes 0101 to 1001
// R12 - slot order for remaining valid codes
// R13 - fifth pin picks external or internal pass
// R14 - all timing from 32.768 kHz control tick
// R15 - reserved code enables nothing, all discharged
package pwrseq_pkg;
  localparam int CLK_HZ      = 40_000_000;
  localparam int CTRL_HZ     = 32_768;
  localparam int DIV_CYCLES  = CLK_HZ / CTRL_HZ;
  // times in tenths of a millisecond, as printed
  localparam int INIT_MS10   = 80;
  localparam int SLOT_MS10   = 20;
  localparam int PWM_MS10    = 30;
  // least times round up to whole control ticks
  localparam int INIT_TICKS  = (INIT_MS10 * CTRL_HZ + 9999) / 10000;
  localparam int SLOT_TICKS  = (SLOT_MS10 * CTRL_HZ + 9999) / 10000;
  localparam int PWM_TICKS   = (PWM_MS10 * CTRL_HZ + 9999) / 10000;
  localparam int NUM_SLOTS   = 10;
  localparam logic [1:0] SYNC_WAIT = 2'h3;

  // register map
  localparam logic [7:0]  ADDR_MODE   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_EN     = 8'h08;
  localparam logic [1:0]  MODE_PWM    = 2'h1;
  localparam logic [9:0]  MODE_RST    = 10'h2AA;

  // configuration code boundaries
  localparam logic [3:0]  CODE_RSVD_HI = 4'h4;
  localparam logic [3:0]  CODE_A_HI    = 4'h9;

  // regulator enable bit positions, bucks first
  localparam int R_B1 = 0, R_B2 = 1, R_B3 = 2, R_B4 = 3, R_B5 = 4;
  localparam int R_BST = 5, R_PLL = 6, R_G1 = 7, R_G2 = 8;
  localparam int R_USB = 9, R_USB2 = 10, R_DAC = 11, R_MREF = 12;
  localparam int NUM_REGS = 13;
  localparam int NUM_BUCKS = 5;

  // default levels in millivolts
  typedef logic [11:0] mv_t;
  localparam mv_t MV_0    = 12'h000;
  localparam mv_t MV_1100 = 12'h44C;
  localparam mv_t MV_1200 = 12'h4B0;
  localparam mv_t MV_1225 = 12'h4C9;
  localparam mv_t MV_1300 = 12'h514;
  localparam mv_t MV_1350 = 12'h546;
  localparam mv_t MV_1500 = 12'h5DC;
  localparam mv_t MV_1800 = 12'h708;
  localparam mv_t MV_2500 = 12'h9C4;
  localparam mv_t MV_2775 = 12'hAD7;
  localparam mv_t MV_3100 = 12'hC1C;
  localparam mv_t MV_3150 = 12'hC4E;
  localparam mv_t MV_3300 = 12'hCE4;

  typedef struct packed {
    mv_t buck_pair_one;
    mv_t buck_two;
    mv_t buck_three;
    mv_t buck_pair_four_a;
    mv_t buck_pair_four_b;
    mv_t buck_five;
    mv_t secure_clock;
    mv_t pll;
    mv_t dac;
    mv_t general_one;
    mv_t general_two;
    mv_t usb;
    mv_t usb_two;
  } level_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PRE  = 3'h1,
    ST_SLOT = 3'h2,
    ST_DONE = 3'h3,
    ST_CUT  = 3'h4
  } state_e;
endpackage : pwrseq_pkg

// [tb/power_up_sequencer_tb.sv]
// power_up_sequencer_tb: random codes, power cut, register corner cases
// assumes shortened tick counts; tick is the fixed 1220-cycle divider
`timescale 1ns/100ps
`default_nettype none
module power_up_sequencer_tb;
  import pwrseq_pkg::*;
  localparam int INIT_T = 2;
  localparam int SLOT_T = 1;
  localparam int PWM_T  = 2;
  localparam int PER    = SLOT_T * DIV_CYCLES;
  logic        clk_i, nrst_i, cut, buv, wr, rd, clash;
  logic        dig_en, sec_en, ana_en, pass_int, buv_o, mask;
  logic [4:0]  pins, dis;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [12:0] en, pg, prev_en;
  logic [9:0]  bmode;
  level_s      lv;
  int          error_cnt, checks, cyc, trel;
  logic [31:0] seed;
  logic [12:0] q_m[$];
  int          q_t[$];
  ////////////////////////////////////////////////////////////////////////////
  power_up_sequencer #(.INIT_T(9'(INIT_T)), .SLOT_T(9'(SLOT_T)),
    .PWM_T(9'(PWM_T))) dut_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .power_mode_select_pins_i(pins),
    .power_cut_event_i(cut), .battery_uv_i(buv), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .digital_core_supply_en_o(dig_en), .secure_clock_regulator_en_o(sec_en),
    .analog_core_supply_en_o(ana_en), .reg_en_o(en), .buck_discharge_o(dis),
    .buck_mode_o(bmode), .levels_o(lv), .pass_device_internal_o(pass_int),
    .battery_uv_o(buv_o), .uv_mask_o(mask));
  regulator_bank_model #(.RAMP(40)) bank_u (.clk_i(clk_i), .nrst_i(nrst_i),
    .reg_en_i(en), .discharge_i(dis), .power_good_o(pg), .clash_o(clash));
  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock and a free cycle count for timing the enables
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // newly enabled regulators of one slot; reserved codes enable nothing
  function automatic logic [12:0] slot_mask(input logic [3:0] c, input int s);
    if (c <= CODE_RSVD_HI) return 13'h0;
    if (c <= CODE_A_HI) begin
      case (s)
        0: return 13'h1 << R_B2;
        1: return 13'h1 << R_PLL;
        2: return 13'h1 << R_G2;
        3: return 13'h1 << R_B3;
        4: return 13'h1 << R_B1;
        5: return (13'h1 << R_B4) | (13'h1 << R_MREF);
        7: return (13'h1 << R_B5) | (13'h1 << R_G1);
        8: return (13'h1 << R_USB) | (13'h1 << R_USB2);
        9: return 13'h1 << R_DAC;
        default: return 13'h0;
      endcase
    end
    case (s)
      0: return 13'h1 << R_B2;
      1: return 13'h1 << R_B3;
      2: return 13'h1 << R_B1;
      3: return 13'h1 << R_DAC;
      4: return (13'h1 << R_B4) | (13'h1 << R_MREF);
      5: return 13'h1 << R_B5;
      6: return (13'h1 << R_G2) | (13'h1 << R_USB2);
      7: return 13'h1 << R_PLL;
      8: return 13'h1 << R_G1;
      default: return 13'h1 << R_USB;
    endcase
  endfunction : slot_mask
  // code-dependent levels checked here: buck two, general two, dac
  function automatic logic [35:0] exp_lv(input logic [3:0] c);
    mv_t b2;
    mv_t g2;
    mv_t dac;
    b2 = (c == 4'h5) ? MV_1225 : (c <= CODE_A_HI) ? MV_1300 : MV_1200;
    g2 = (c >= 4'hA && c <= 4'hD) ? MV_3100 : MV_2500;
    dac = (c <= CODE_A_HI) ? MV_2775 : MV_2500;
    return {b2, g2, dac};
  endfunction : exp_lv
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic end_of_test();
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  ////////////////////////////////////////////////////////////////////////////
  // record each new enable and its cycle; sampled mid-cycle to avoid races
  always @(negedge clk_i) begin
    if (nrst_i && !cut && en !== prev_en) begin
      if ((en & ~prev_en) != 13'h0) begin
        q_m.push_back(en & ~prev_en);
        q_t.push_back(cyc);
      end
      cmp(40'(dis ^ en[4:0]), 40'h1F, "discharge");
      cmp(40'(clash), 40'h0, "driven while discharged");
    end
    prev_en = en;
  end
  // one full power-up with a given code, optionally cut in mid-sequence
  task automatic run(input logic [3:0] code, input logic do_cut);
    logic [31:0] d;
    logic [9:0]  mode;
    logic        psel;
    logic [12:0] all;
    int          n;
    int          k;
    mode = 10'(rnd());
    psel = 1'(rnd());
    @(posedge clk_i);
    nrst_i <= 1'b0;
    pins   <= {psel, code};
    repeat (20) @(posedge clk_i);
    cmp(40'({bmode, dis}), 40'({MODE_RST, 5'h1F}), "reset outputs");
    nrst_i <= 1'b1;
    trel = cyc;
    q_m.delete();
    q_t.delete();
    rd_reg(ADDR_MODE, d);
    cmp(40'(d), 40'(MODE_RST), "mode reset value");
    wr_reg(ADDR_MODE, 32'(mode));
    wr_reg(ADDR_EN, 32'hFFFFFFFF);
    rd_reg(ADDR_EN, d);
    cmp(40'(d), 40'h0, "nothing on before pre phase ends");
    rd_reg(8'h0C, d);
    cmp(40'(d), 40'h0, "unmapped read");
    @(posedge clk_i);
    pins <= ~{psel, code};
    repeat (8) @(posedge clk_i);
    cmp(40'({dig_en, sec_en, ana_en}), 40'h7, "core supplies");
    cmp(40'({mask, buv_o}), 40'h2, "uv masked");
    cmp(40'(pass_int), 40'(psel), "pass device");
    if (code <= CODE_RSVD_HI) begin
      cmp(40'(lv !== '0), 40'h0, "reserved levels");
    end else begin
      cmp(40'({lv.buck_pair_one, lv.buck_five}), 40'({MV_1100, MV_1800}),
          "fixed levels");
      cmp(40'({lv.pll, lv.usb, lv.usb_two}),
          40'({MV_1800, MV_3300, MV_2500}), "rail levels");
      cmp(40'({lv.buck_two, lv.general_two, lv.dac}), 40'(exp_lv(code)),
          "code levels");
    end
    if (do_cut) begin
      for (k = 0; k < 8 * DIV_CYCLES && q_m.size() < 3; k++) @(posedge clk_i);
      cmp(40'(q_m.size() >= 3), 40'h1, "slots before cut");
      cut <= 1'b1;
      repeat (10) @(posedge clk_i);
      cmp(40'({en, ana_en, dig_en}), 40'h1, "supplies in cut");
      cut <= 1'b0;
      trel = cyc;
      q_m.delete();
      q_t.delete();
    end
    if (code > CODE_RSVD_HI) begin
      for (k = 0; k < 8 * DIV_CYCLES && en[R_B2] !== 1'b1; k++)
        @(posedge clk_i);
      cmp(40'(en[R_B2]), 40'h1, "buck two enabled");
      repeat (2) @(posedge clk_i);
      #1 cmp(40'(bmode[2*R_B2 +: 2]), 40'(MODE_PWM), "forced pwm");
    end
    for (k = 0; k < 20 * DIV_CYCLES && mask !== 1'b0; k++) @(posedge clk_i);
    cmp(40'(mask), 40'h0, "sequence finished");
    n = 0;
    all = 13'h0;
    for (int s = 0; s < NUM_SLOTS; s++) begin
      if (slot_mask(code, s) != 13'h0) begin
        all = all | slot_mask(code, s);
        if (n < q_m.size()) begin
          cmp(40'(q_m[n]), 40'(slot_mask(code, s)), "slot order");
          cmp(40'(q_t[n] - q_t[0]), 40'(s * PER), "slot time");
        end
        n++;
      end
    end
    cmp(40'(q_m.size()), 40'(n), "enable count");
    if (q_t.size() > 0) begin
      cmp(40'(q_t[0] - trel >= (INIT_T - 1) * DIV_CYCLES &&
              q_t[0] - trel <= (INIT_T + 1) * DIV_CYCLES + 8), 40'h1,
          "pre phase length");
    end
    cmp(40'(en[R_BST]), 40'h0, "boost off");
    repeat (5) @(posedge clk_i);
    #1 cmp(40'({mask, buv_o}), 40'h1, "uv unmasked");
    repeat ((PWM_T + 1) * DIV_CYCLES) @(posedge clk_i);
    #1 cmp(40'(bmode), 40'(mode), "programmed mode");
    cmp(40'(pg), 40'(all), "regulators up");
    rd_reg(ADDR_EN, d);
    cmp(40'(d), 40'(all), "enable register");
    rd_reg(ADDR_STATUS, d);
    cmp(40'(d), 40'({5'h0, 1'b0, 1'b1, psel, code, ST_DONE}),
        "latched status");
  endtask : run
  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the four runs need about 54k cycles, so 90k means a hang
  initial begin
    #(25 * 90000);
    error_cnt++;
    end_of_test();
  end
  // main sequence: both order tables, a cut, reserved corner and random
  initial begin
    seed      = 32'h1121;
    nrst_i    = 1'b0;
    cut       = 1'b0;
    buv       = 1'b1;
    wr        = 1'b0;
    rd        = 1'b0;
    pins      = 5'h00;
    addr      = 8'h00;
    wdata     = 32'h0;
    prev_en   = 13'h0;
    cyc       = 0;
    error_cnt = 0;
    checks    = 0;
    run(4'h5 + 4'(rnd() % 5), 1'b0);
    run(4'hA + 4'(rnd() % 6), 1'b1);
    run(4'h4, 1'b0);
    run(4'(rnd() % 4), 1'b0);
    end_of_test();
  end
endmodule : power_up_sequencer_tb
`default_nettype wire

// [tb/regulator_bank_model.sv]
// regulator bank model: ramps each enabled output, drops it when off
// assumes enables and buck pull-downs come from the sequencer, one clock
`timescale 1ns/100ps
`default_nettype none
module regulator_bank_model #(
  parameter int RAMP = 40
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic [12:0] reg_en_i,
  input  wire logic [4:0]  discharge_i,
  output logic      [12:0] power_good_o,
  output logic             clash_o
);
  logic [7:0] ramp_q [13];
  ////////////////////////////////////////////////////////////////////////////
  // a buck both switched on and pulled down would fight its own load
  assign clash_o = |(reg_en_i[4:0] & discharge_i);
  // outputs reach regulation a fixed time after enable, lost at once when off
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 13; i++) ramp_q[i] <= 8'h00;
      power_good_o <= '0;
    end else begin
      for (int i = 0; i < 13; i++) begin
        if (!reg_en_i[i]) ramp_q[i] <= 8'h00;
        else if (ramp_q[i] != 8'(RAMP)) ramp_q[i] <= ramp_q[i] + 8'h01;
        power_good_o[i] <= reg_en_i[i] && ramp_q[i] == 8'(RAMP);
      end
    end
  end
endmodule : regulator_bank_model
`default_nettype wire
